// [verilog/eep_node_id_top.sv]
// Two-wire EEPROM slave with protected node identity in the upper half.
// Assumes scl/sda arrive unsynchronised; link_clk_i oversamples them and
// runs freely; clk_i clocks only the write-cycle timer.
`timescale 1ns/100ps
`default_nettype none
`include "eep_regs.svh"

module eep_node_id_top #(
  parameter logic [31:0] WC_CYCLES = `EEP_WC_CYCLES,
  parameter bit          ID_IS_64  = 1'b0,
  parameter logic [23:0] ID_OUI    = 24'h5a3c96,     // Arbitrary value
  parameter logic [39:0] ID_EXT    = 40'h0102030405  // Arbitrary value
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic link_clk_i,
  input  wire logic scl_i,
  input  wire logic sda_i,
  output var  logic sda_o,
  output var  logic sda_oe_o
);

  eep_wc_if wc_bus ();

  eep_pkg::eep_state_t state;
  logic [7:0]          mem_lo [`EEP_LO_DEPTH];
  logic                scl_meta;
  logic                scl_sync;
  logic                scl_dly;
  logic                sda_meta;
  logic                sda_sync;
  logic                sda_dly;
  logic                busy_meta;
  logic                busy_sync;
  logic                ev_start;
  logic                ev_stop;
  logic                ev_rise;
  logic                ev_fall;
  logic [3:0]          rcnt;
  logic [7:0]          shreg;
  logic [7:0]          ptr;
  logic [7:0]          tx;
  logic [7:0]          rd_cur;
  logic                acked;
  logic                rd_dir;
  logic                wr_pend;
  logic                ctrl_match;
  logic                mack;
  logic                byte_end;
  logic                ack_end;

  // ========================================================================
  // Identity and array read path
  function automatic logic [7:0] id_byte(input logic [7:0] a);
    logic [7:0] off;
    id_byte = `EEP_FILL_BYTE;
    off     = 8'h0;
    if (ID_IS_64) begin
      if (a >= `EEP_ID64_BASE) begin
        off = a - `EEP_ID64_BASE;
        if (off < `EEP_OUI_BYTES) begin
          id_byte = ID_OUI[8*(2-int'(off)) +: 8];
        end else begin
          id_byte = ID_EXT[8*(7-int'(off)) +: 8];
        end
      end
    end else if (a >= `EEP_ID48_BASE) begin
      off = a - `EEP_ID48_BASE;
      if (off < `EEP_OUI_BYTES) begin
        id_byte = ID_OUI[8*(2-int'(off)) +: 8];
      end else begin
        id_byte = ID_EXT[8*(5-int'(off)) +: 8];
      end
    end
  endfunction

  // Upper half comes from constants, so no write path can reach it
  assign rd_cur = ptr[`EEP_PROT_BIT] ? id_byte(ptr) : mem_lo[ptr[6:0]];

  // ========================================================================
  // Pin synchronisers; meta flops feed only their sync flop
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_meta <= 1'b1;
      scl_sync <= 1'b1;
      scl_dly  <= 1'b1;
      sda_meta <= 1'b1;
      sda_sync <= 1'b1;
      sda_dly  <= 1'b1;
    end else begin
      scl_meta <= scl_i;
      scl_sync <= scl_meta;
      scl_dly  <= scl_sync;
      sda_meta <= sda_i;
      sda_sync <= sda_meta;
      sda_dly  <= sda_sync;
    end
  end

  // Busy level from the timer domain
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      busy_meta <= 1'b0;
      busy_sync <= 1'b0;
    end else begin
      busy_meta <= wc_bus.wc_busy;
      busy_sync <= busy_meta;
    end
  end

  // Bus conditions: sda moving while scl high marks Start or Stop
  assign ev_start   = scl_sync & scl_dly & sda_dly & ~sda_sync;
  assign ev_stop    = scl_sync & scl_dly & ~sda_dly & sda_sync;
  assign ev_rise    = scl_sync & ~scl_dly;
  assign ev_fall    = ~scl_sync & scl_dly;
  assign ctrl_match = (shreg[7:4] == `EEP_CTRL_CODE);
  assign mack       = ~shreg[0];
  assign byte_end   = ev_fall && (rcnt == `EEP_CNT_BYTE_DONE);
  assign ack_end    = ev_fall && (rcnt == `EEP_CNT_ACK_DONE);

  // ========================================================================
  // Bit capture on scl rise; counts rises so the fall after Start is inert
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shreg <= 8'h0;
      rcnt  <= 4'h0;
    end else if (ev_start || ev_stop) begin
      rcnt  <= 4'h0;
    end else if (ev_rise && state != eep_pkg::EEP_IDLE) begin
      shreg <= {shreg[6:0], sda_sync};
      rcnt  <= rcnt + 4'h1;
    end else if (ack_end) begin
      rcnt  <= 4'h0;
    end
  end

  // ========================================================================
  // Frame state
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state  <= eep_pkg::EEP_IDLE;
      acked  <= 1'b0;
      rd_dir <= 1'b0;
    end else if (ev_start) begin
      state  <= eep_pkg::EEP_CTRL;
    end else if (ev_stop) begin
      state  <= eep_pkg::EEP_IDLE;
    end else if (byte_end && state == eep_pkg::EEP_CTRL) begin
      acked  <= ctrl_match && !busy_sync;
      rd_dir <= shreg[0];
    end else if (ack_end) begin
      unique case (state)
        eep_pkg::EEP_CTRL: begin
          if (!acked) begin
            state <= eep_pkg::EEP_IDLE;
          end else if (rd_dir) begin
            state <= eep_pkg::EEP_RDATA;
          end else begin
            state <= eep_pkg::EEP_ADDR;
          end
        end
        eep_pkg::EEP_ADDR:  state <= eep_pkg::EEP_WDATA;
        eep_pkg::EEP_WDATA: state <= eep_pkg::EEP_WDATA;
        eep_pkg::EEP_RDATA: state <= mack ? eep_pkg::EEP_RDATA
                                          : eep_pkg::EEP_IDLE;
        eep_pkg::EEP_IDLE:  state <= eep_pkg::EEP_IDLE;
      endcase
    end
  end

  // ========================================================================
  // Address pointer; 8-bit arithmetic wraps FF to 00 by itself
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ptr <= 8'h0;
    end else if (!ev_start && !ev_stop) begin
      if (byte_end && state == eep_pkg::EEP_ADDR) begin
        ptr <= shreg;
      end else if (byte_end && state == eep_pkg::EEP_WDATA) begin
        ptr <= ptr + 8'h1;
      end else if (ack_end && state == eep_pkg::EEP_CTRL && acked && rd_dir) begin
        ptr <= ptr + 8'h1;
      end else if (ack_end && state == eep_pkg::EEP_RDATA && mack) begin
        ptr <= ptr + 8'h1;
      end
    end
  end

  // ========================================================================
  // Lower-half storage; bytes land as they arrive
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `EEP_LO_DEPTH; i++) begin
        mem_lo[i] <= `EEP_LO_RESET;
      end
    end else if (byte_end && state == eep_pkg::EEP_WDATA && !ev_start
                 && !ptr[`EEP_PROT_BIT]) begin
      mem_lo[ptr[6:0]] <= shreg;
    end
  end

  // Write cycle request: only a Stop after a stored byte starts it
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_pend           <= 1'b0;
      wc_bus.wc_req_tgl <= 1'b0;
    end else if (ev_stop) begin
      wr_pend <= 1'b0;
      if (wr_pend) begin
        wc_bus.wc_req_tgl <= ~wc_bus.wc_req_tgl;
      end
    end else if (byte_end && state == eep_pkg::EEP_WDATA && !ptr[`EEP_PROT_BIT]) begin
      wr_pend <= 1'b1;
    end
  end

  // ========================================================================
  // Data line drive, changed on scl fall and released on Start or Stop; open drain pulls low only
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_oe_o <= 1'b0;
      tx       <= 8'h0;
    end else if (ev_start || ev_stop) begin
      sda_oe_o <= 1'b0;
    end else if (byte_end) begin
      unique case (state)
        eep_pkg::EEP_CTRL:  sda_oe_o <= ctrl_match && !busy_sync;
        eep_pkg::EEP_ADDR:  sda_oe_o <= 1'b1;
        eep_pkg::EEP_WDATA: sda_oe_o <= 1'b1;
        eep_pkg::EEP_RDATA: sda_oe_o <= 1'b0;
        eep_pkg::EEP_IDLE:  sda_oe_o <= 1'b0;
      endcase
    end else if (ack_end) begin
      if ((state == eep_pkg::EEP_CTRL && acked && rd_dir)
          || (state == eep_pkg::EEP_RDATA && mack)) begin
        sda_oe_o <= ~rd_cur[7];
        tx       <= {rd_cur[6:0], 1'b0};
      end else begin
        sda_oe_o <= 1'b0;
      end
    end else if (ev_fall && state == eep_pkg::EEP_RDATA && rcnt != 4'h0) begin
      sda_oe_o <= ~tx[7];
      tx       <= {tx[6:0], 1'b0};
    end
  end

  // Line level when driven is always low
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sda_o <= 1'b0;
    end else begin
      sda_o <= 1'b0;
    end
  end

  eep_wc_timer #(
    .WC_CYCLES (WC_CYCLES)
  ) u_wc_timer (
    .clk_i     (clk_i),
    .rst_n_i   (rst_n_i),
    .wc        (wc_bus.timer)
  );

  // ========================================================================
  // Checks
  default clocking cb @(posedge link_clk_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_ctrl_byte;
    byte_end && state == eep_pkg::EEP_CTRL && !ev_start && !ev_stop;
  endsequence

  sequence s_rd_acked;
    ack_end && state == eep_pkg::EEP_RDATA && mack && !ev_start && !ev_stop;
  endsequence

  AST_BUSY_NOACK: assert property (s_ctrl_byte and busy_sync |=> !sda_oe_o)
    else $error("control byte acknowledged during write cycle");

  AST_IDLE_ACK: assert property (
    s_ctrl_byte and (!busy_sync && ctrl_match) |=> sda_oe_o)
    else $error("control byte not acknowledged when idle");

  AST_DIR_READ: assert property (
    ack_end && state == eep_pkg::EEP_CTRL && acked && rd_dir
    |=> state == eep_pkg::EEP_RDATA)
    else $error("read control byte did not enter read");

  AST_ADDR_LOAD: assert property (
    byte_end && state == eep_pkg::EEP_ADDR && !ev_start && !ev_stop
    |=> ptr == $past(shreg))
    else $error("word address not loaded into pointer");

  AST_SEQ_NEXT: assert property (s_rd_acked |=> ptr == $past(ptr) + 8'h1
    && state == eep_pkg::EEP_RDATA && tx == {$past(rd_cur[6:0]), 1'b0})
    else $error("sequential read did not advance");

  AST_NACK_RELEASE: assert property (
    ack_end && state == eep_pkg::EEP_RDATA && !mack && !ev_start && !ev_stop
    |=> !sda_oe_o && state == eep_pkg::EEP_IDLE)
    else $error("data line held after master NACK");

  AST_WR_STORE: assert property (
    byte_end && state == eep_pkg::EEP_WDATA && !ptr[`EEP_PROT_BIT] && !ev_start
    |=> mem_lo[$past(ptr[6:0])] == $past(shreg) && ptr == $past(ptr) + 8'h1)
    else $error("lower-half write not stored");

  AST_PROT_NOREQ: assert property (
    byte_end && state == eep_pkg::EEP_WDATA && ptr[`EEP_PROT_BIT] && !ev_start
    |=> $stable(wr_pend) && mem_lo[$past(ptr[6:0])] == $past(mem_lo[ptr[6:0]]))
    else $error("protected write started a write cycle");

  AST_ID_EXT64: assert property (
    !(ID_IS_64 && (ID_EXT[39:24] == `EEP_ID_RSVD_A
                   || ID_EXT[39:24] == `EEP_ID_RSVD_B)))
    else $error("long identifier extension uses a reserved prefix");

  AST_PTR_WRAP: assert property (s_rd_acked and ptr == `EEP_ID_LAST |=> ptr == 8'h0)
    else $error("pointer did not wrap to zero");

endmodule // eep_node_id_top

`default_nettype wire

// [verilog/eep_regs.svh]
// Constants for the two-wire EEPROM node-identity slave.
// Assumes inclusion by bare name from the design files.
`ifndef EEP_REGS_SVH
`define EEP_REGS_SVH

// ==========================================================================
// Protocol
`define EEP_CTRL_CODE      4'ha
`define EEP_CNT_BYTE_DONE  4'd8
`define EEP_CNT_ACK_DONE   4'd9
`define EEP_PROT_BIT       7

// ==========================================================================
// Array layout
`define EEP_LO_DEPTH       128
`define EEP_LO_RESET       8'hff
`define EEP_FILL_BYTE      8'hff
`define EEP_ID48_BASE      8'hfa
`define EEP_ID64_BASE      8'hf8
`define EEP_ID_LAST        8'hff
`define EEP_OUI_BYTES      8'd3
`define EEP_ID_RSVD_A      16'hfffe
`define EEP_ID_RSVD_B      16'hffff

// ==========================================================================
// Timing
`define EEP_CLK_PERIOD_NS  5
`define EEP_WC_TIME_NS     5000000
`define EEP_WC_CYCLES      ((`EEP_WC_TIME_NS + `EEP_CLK_PERIOD_NS - 1) / `EEP_CLK_PERIOD_NS)

`endif

// [verilog/eep_pkg.sv]
// Types shared by the EEPROM node-identity slave.
// Assumes nothing of its surroundings.
`default_nettype none

package eep_pkg;

  // ========================================================================
  // Link-side protocol states
  typedef enum logic [2:0] {
    EEP_IDLE,
    EEP_CTRL,
    EEP_ADDR,
    EEP_WDATA,
    EEP_RDATA
  } eep_state_t;

endpackage

`default_nettype wire

// [verilog/eep_wc_if.sv]
// Carrier between the link-side engine and the write-cycle timer.
// Assumes the request is a toggle and busy a level; both cross domains.
`timescale 1ns/100ps
`default_nettype none

interface eep_wc_if;
  logic wc_req_tgl;  // Link domain: flips once per finished write
  logic wc_busy;     // System domain: internal write cycle running

  modport link  (output wc_req_tgl, input wc_busy);
  modport timer (input wc_req_tgl, output wc_busy);
endinterface

`default_nettype wire

// [verilog/eep_wc_timer.sv]
// Self-timed write cycle timer on the system clock.
// Assumes the request toggle comes from the link clock domain.
`timescale 1ns/100ps
`default_nettype none
`include "eep_regs.svh"

module eep_wc_timer #(
  parameter logic [31:0] WC_CYCLES = `EEP_WC_CYCLES
) (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  eep_wc_if.timer   wc
);

  logic        tgl_meta;
  logic        tgl_sync;
  logic        tgl_seen;
  logic        start_pulse;
  logic [31:0] remain;

  // ========================================================================
  // Toggle crossing: meta flop feeds only the sync flop
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tgl_meta <= 1'b0;
      tgl_sync <= 1'b0;
      tgl_seen <= 1'b0;
    end else begin
      tgl_meta <= wc.wc_req_tgl;
      tgl_sync <= tgl_meta;
      tgl_seen <= tgl_sync;
    end
  end

  assign start_pulse = tgl_sync ^ tgl_seen;

  // ========================================================================
  // Countdown; busy runs in the system domain so a stopped link clock
  // cannot freeze the cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      remain     <= 32'h0;
      wc.wc_busy <= 1'b0;
    end else if (start_pulse) begin
      remain     <= WC_CYCLES;
      wc.wc_busy <= 1'b1;
    end else begin
      if (remain != 32'h0) begin
        remain <= remain - 32'h1;
      end
      wc.wc_busy <= (remain > 32'h1);
    end
  end

  // ========================================================================
  // Checks
  AST_WC_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    start_pulse |=> wc.wc_busy [*8])
    else $error("write cycle busy dropped early");

  AST_WC_END: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (remain == 32'h1 && !start_pulse) |=> !wc.wc_busy)
    else $error("write cycle busy outlived its count");

endmodule // eep_wc_timer

`default_nettype wire

// [bench/eep_bus_master.sv]
// Behavioural two-wire bus master that clocks the slave under test.
// Assumes the bench forms the open-drain data wire with a pull-up.
`timescale 1ns/100ps
`default_nettype none
`include "eep_regs.svh"

module eep_bus_master (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output var  logic scl_o,
  output var  logic sda_o
);
  // ==========================================================================
  // Bit timing
  localparam int QTR = 40;  // 200 ns; an 800 ns low phase leaves the slave time to answer

  // Idle bus: both lines released
  initial begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Whole sixths of a bit, counted on the system clock
  task automatic qwait(input int n);
    repeat (n * QTR) @(posedge clk_i);
  endtask

  // One clock pulse; data moves only while the clock is low
  task automatic bit_io(input logic b, output logic s);
    qwait(1);
    sda_o <= b;
    qwait(3);
    scl_o <= 1'b1;
    qwait(1);
    s = sda_i;
    qwait(1);
    scl_o <= 1'b0;
  endtask

  // ==========================================================================
  // Framing
  // Waits a full low phase so a slave still holding its ACK has let go
  task automatic start();
    qwait(1);
    sda_o <= 1'b1;
    qwait(3);
    scl_o <= 1'b1;
    qwait(2);
    sda_o <= 1'b0;
    qwait(2);
    scl_o <= 1'b0;
  endtask

  // Stop leaves both lines released
  task automatic stop();
    qwait(1);
    sda_o <= 1'b0;
    qwait(3);
    scl_o <= 1'b1;
    qwait(2);
    sda_o <= 1'b1;
    qwait(2);
  endtask

  // Byte out MSB first; ninth clock returns the slave's acknowledge
  task automatic send(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    ack = ~s;
  endtask

  // Byte in; our acknowledge asks for one more
  task automatic recv(input logic ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(~ack, s);
  endtask

  // ==========================================================================
  // Commands
  // Start plus control byte; the low bit picks the direction
  task automatic control(input logic rd, output logic ack);
    start();
    send({`EEP_CTRL_CODE, 3'b000, rd}, ack);
  endtask

  // Word address sent, transfer left open for data or a repeated start
  task automatic set_addr(input logic [7:0] a, output logic ack);
    logic a1;
    control(1'b0, a1);
    send(a, ack);
    ack = ack & a1;
  endtask

  // Write-direction polls until answered or out of tries
  task automatic poll(input int tries, output int n, output logic ack);
    n = 0;
    ack = 1'b0;
    while (!ack && n < tries) begin
      control(1'b0, ack);
      stop();
      n++;
    end
  endtask
endmodule  // eep_bus_master

`default_nettype wire

// [bench/test_eep_node_id_top.sv]
// Self-checking bench for the two-wire EEPROM node-identity slave.
// Assumes the design files and the bus master model compile first.
`timescale 1ns/100ps
`default_nettype none

module test_eep_node_id_top;
  localparam logic [23:0] OUI   = 24'h5a3c96;      // Arbitrary value
  localparam logic [39:0] EXT   = 40'h1122334455;  // Arbitrary value
  localparam logic [23:0] WDATA = 24'h5aa53c;
  localparam logic [63:0] ID64   = {OUI, EXT};
  localparam logic [47:0] ID48   = {OUI, EXT[23:0]};
  localparam logic [63:0] EUI48W = {OUI, 16'hfffe, EXT[23:0]};
  logic      clk;
  logic      rd48;
  logic      sda48_oe;
  wire logic sda48;
  logic      link_clk;
  logic      rst_n;
  logic      scl;
  logic      m_sda;
  logic      sda_drv;
  logic      sda_oe;
  wire logic sda_wire;
  int        n_fail;
  int        n_compared;

  // ==========================================================================
  // Wiring
  // Open-drain data wire with pull-up
  assign sda_wire = m_sda & ~sda_oe;
  // Short-identifier twin hears the same traffic on a wire of its own
  assign sda48    = m_sda & ~sda48_oe;

  eep_node_id_top #(
    .WC_CYCLES (32'd3000),
    .ID_IS_64  (1'b1),
    .ID_OUI    (OUI),
    .ID_EXT    (EXT)
  ) i_dut (
    .clk_i      (clk),
    .rst_n_i    (rst_n),
    .link_clk_i (link_clk),
    .scl_i      (scl),
    .sda_i      (sda_wire),
    .sda_o      (sda_drv),
    .sda_oe_o   (sda_oe)
  );

  eep_node_id_top #(
    .WC_CYCLES (32'd3000),
    .ID_IS_64  (1'b0),
    .ID_OUI    (OUI),
    .ID_EXT    (EXT)
  ) i_dut48 (
    .clk_i      (clk),
    .rst_n_i    (rst_n),
    .link_clk_i (link_clk),
    .scl_i      (scl),
    .sda_i      (sda48),
    .sda_o      (),
    .sda_oe_o   (sda48_oe)
  );

  // Master hears one slave at a time; both take every command
  eep_bus_master i_master (
    .clk_i (clk),
    .sda_i (rd48 ? sda48 : sda_wire),
    .scl_o (scl),
    .sda_o (m_sda)
  );

  // ==========================================================================
  // Clocks and watchdog
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // Link clock offset so its edges never line up with the system clock
  initial begin
    link_clk = 1'b0;
    #37.3;
    forever #80 link_clk = ~link_clk;
  end
  initial begin
    repeat (100000) @(posedge clk);
    n_fail++;
    summarize();
  end

  // ==========================================================================
  // Checking
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // ==========================================================================
  // Scenarios
  // Three-byte write at 0, then polls while the write cycle runs
  task automatic test_write_poll();
    logic ack;
    int   n;
    i_master.set_addr(8'h00, ack);
    check({7'h0, ack}, 8'h01);
    for (int i = 0; i < 3; i++) begin
      i_master.send(WDATA[23 - 8 * i -: 8], ack);
      check({7'h0, ack}, 8'h01);
    end
    i_master.stop();
    i_master.poll(1, n, ack);
    check({7'h0, ack}, 8'h00);
    i_master.poll(4, n, ack);
    check({7'h0, ack}, 8'h01);
  endtask

  // Random read at 0 carried on sequentially, ended by our NACK
  task automatic test_random_seq();
    logic       ack;
    logic [7:0] d;
    i_master.set_addr(8'h00, ack);
    i_master.control(1'b1, ack);
    check({7'h0, ack}, 8'h01);
    i_master.recv(1'b1, d);
    check(d, 8'h5a);
    i_master.recv(1'b0, d);
    check(d, 8'ha5);
    i_master.stop();
    check({7'h0, sda_wire}, 8'h01);
  endtask

  // Current address read picks up after the last byte read
  task automatic test_current();
    logic       ack;
    logic [7:0] d;
    i_master.control(1'b1, ack);
    i_master.recv(1'b0, d);
    check(d, 8'h3c);
    i_master.stop();
  endtask

  // Write into the identity area: accepted but neither stored nor timed
  task automatic test_protect();
    logic ack;
    int   n;
    i_master.set_addr(8'hf8, ack);
    check({7'h0, ack}, 8'h01);
    i_master.send(8'h00, ack);
    i_master.stop();
    i_master.poll(1, n, ack);
    check({7'h0, ack}, 8'h01);
  endtask

  // Whole identifier in one sequential read, then wrap to location 0
  task automatic test_id_read();
    logic        ack;
    logic [7:0]  d;
    logic [63:0] id;
    i_master.set_addr(8'hf8, ack);
    i_master.control(1'b1, ack);
    for (int i = 0; i < 8; i++) begin
      i_master.recv(1'b1, d);
      id[63 - 8 * i -: 8] = d;
      check(d, ID64[63 - 8 * i -: 8]);
    end
    check({7'h0, id[39:24] !== 16'hfffe && id[39:24] !== 16'hffff}, 8'h01);
    i_master.recv(1'b0, d);
    check(d, 8'h5a);
    i_master.stop();
  endtask

  // Short identifier read from the twin, then wrapped to 64 bits by the host
  task automatic test_id48();
    logic        ack;
    logic [7:0]  d;
    logic [47:0] got;
    logic [63:0] eui;
    rd48 <= 1'b1;
    i_master.set_addr(8'hfa, ack);
    i_master.control(1'b1, ack);
    for (int i = 0; i < 6; i++) begin
      i_master.recv(i < 5, d);
      got[47 - 8 * i -: 8] = d;
      check(d, ID48[47 - 8 * i -: 8]);
    end
    i_master.stop();
    rd48 <= 1'b0;
    eui = {got[47:24], 16'hfffe, got[23:0]};
    for (int i = 0; i < 8; i++) check(eui[63 - 8 * i -: 8], EUI48W[63 - 8 * i -: 8]);
  endtask

  // ==========================================================================
  // Main sequence
  initial begin
    n_fail = 0;
    n_compared = 0;
    rd48 = 1'b0;
    rst_n = 1'b0;
    repeat (2) @(posedge link_clk);
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge link_clk);
    @(posedge clk);
    check({6'h0, sda_drv, sda_oe}, 8'h00);
    test_write_poll();
    test_random_seq();
    test_current();
    test_protect();
    test_id_read();
    test_id48();
    summarize();
  end
endmodule  // test_eep_node_id_top

`default_nettype wire
